// *** logic/cpms_pkg.sv ***
/*
  Constants, types and mode encodings for the chip power-mode sequencer.
  Assumes one system clock and a plain strobe register port from the core.
*/
// Summary of operation
// RULE1 - Reset enters normal run unless boot option set
// RULE2 - Normal run keeps regulator at full capability
// RULE3 - High-speed run only on run-mode select write
// RULE4 - Leave high-speed run on rewrite or reset
// RULE5 - Refuse low-power requests while in high-speed run
// RULE6 - Block flash program and erase in high-speed
// RULE7 - Hold oscillator and pins until isolation acknowledged
// RULE8 - Low interrupt pin at reset: service first
// RULE9 - Very-low-power stop: detector off, clocks stopped
// RULE10 - Full low-leak stops: few peripherals, all RAM
// RULE11 - Software keeps wake interrupt unmasked before stop
// RULE12 - Partial low-leak stop: lower voltage, partition rules
// RULE13 - Deep stop three keeps both SRAM regions
// RULE14 - Deep stop two: lower off, partitions optional
// RULE15 - Deep stop one: SRAM off, register files kept
// RULE16 - Deep stop zero: oscillator off, optional POR
// RULE17 - Backup-only mode: battery domain alone stays powered
// RULE18 - Low-leak wake resumes after stop, not reset
// RULE19 - Every low-leak wake sets the wake flag
// RULE20 - Stay stopped until wake or reset, then return
package cpms_pkg;

  // Register indices
  localparam logic [3:0] ADDR_RUN_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STOP_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STOP_REQ = 4'h2;
  localparam logic [3:0] ADDR_ISO_ACK = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESET_STATUS = 4'h5;
  localparam logic [3:0] ADDR_DOMAINS = 4'h6;

  // Field positions
  localparam int RUN_MODE_SELECT_LSB = 0;
  localparam int RAM2_BIT = 0;
  localparam int PORKEEP_BIT = 1;
  localparam int WAKE_BIT = 0;
  localparam int RESUME_BIT = 1;
  localparam int ACK_BIT = 0;

  // Run-mode select encodings
  localparam logic [1:0] RUN_MODE_SELECT_NORMAL = 2'h0;
  localparam logic [1:0] RUN_MODE_SELECT_LOW_POWER = 2'h2;
  localparam logic [1:0] RUN_MODE_SELECT_HIGH_SPEED = 2'h3;

  // Regulator settings
  localparam logic [1:0] REG_FULL = 2'h0;
  localparam logic [1:0] REG_LOW_POWER = 2'h1;
  localparam logic [1:0] REG_HIGH_SPEED = 2'h2;
  localparam logic [1:0] REG_RETENTION = 2'h3;

  // Stop kinds requested by software
  typedef enum logic [3:0] {
    STOP_NONE = 4'h0,
    STOP_VLP = 4'h1,
    STOP_LL_FULL = 4'h2,
    STOP_LL_PARTIAL = 4'h3,
    STOP_DEEP3 = 4'h4,
    STOP_DEEP2 = 4'h5,
    STOP_DEEP1 = 4'h6,
    STOP_DEEP0 = 4'h7,
    STOP_BACKUP = 4'h8
  } cpms_stop_type;

  // Domain enables driven during a mode
  typedef struct packed {
    logic undervoltage_detect_on;
    logic periph_clk_on;
    logic nested_irq_ctrl_on;
    logic async_wake_ctrl_on;
    logic leakage_wake_unit_on;
    logic lptimer_cmp_touch_dac_on;
    logic clock_calendar_on;
    logic adc_pin_irq_on;
    logic ram_part1_on;
    logic ram_part2_on;
    logic ram_part3_on;
    logic sram_upper_on;
    logic sram_lower_on;
    logic sys_regfile_on;
    logic backup_regfile_on;
    logic logic_state_kept;
    logic low_voltage_logic;
    logic io_hold;
    logic osc_hold;
    logic low_power_osc_on;
    logic por_on;
    logic core_power_on;
  } cpms_domains_type;

  localparam int DOMAIN_W = $bits(cpms_domains_type);

endpackage

// *** logic/cpms_sequencer.sv ***
/*
  Chip power-mode sequencer: run-mode selection, stop-mode domain control,
  wake and isolation release. Assumes strobes and wake inputs synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cpms_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Boot straps
  input wire logic low_power_run_boot,
  input wire logic nmi_pin_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core stop entry and wake
  input wire logic deep_sleep_req,
  input wire logic wake_event,
  // Status towards the system
  output logic [1:0] regulator_mode,
  output logic high_speed_run,
  output logic low_power_run,
  output logic flash_prog_block,
  output logic nmi_first,
  output logic wake_via_reset,
  output logic resume_pulse,
  output cpms_pkg::cpms_domains_type domains
);

  typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_STOP, ST_WAKE} cpms_state_type;

  ////////////////////////////////////////////////////////////////////////
  cpms_state_type state_reg, state_next;
  logic [1:0] run_mode_reg, run_mode_next;
  logic [1:0] stop_ctrl_reg, stop_ctrl_next;
  cpms_pkg::cpms_stop_type stop_sel_reg, stop_sel_next;
  cpms_pkg::cpms_stop_type stop_act_reg, stop_act_next;
  logic iso_hold_reg, iso_hold_next;
  logic wake_flag_reg, wake_flag_next;
  logic resume_flag_reg, resume_flag_next;
  logic nmi_first_reg, nmi_first_next;
  logic reset_wake_reg, reset_wake_next;
  logic resume_reg, resume_next;
  logic [31:0] rdata_reg, rdata_next;
  cpms_pkg::cpms_domains_type dom_reg, dom_next;
  logic [1:0] regm_reg, regm_next;

  logic wr_run, wr_stop_ctrl, wr_stop_req, wr_ack;
  logic deep_stop, low_leak_stop;

  assign wr_run = reg_wr && reg_addr == cpms_pkg::ADDR_RUN_CTRL;
  assign wr_stop_ctrl = reg_wr && reg_addr == cpms_pkg::ADDR_STOP_CTRL;
  assign wr_stop_req = reg_wr && reg_addr == cpms_pkg::ADDR_STOP_REQ;
  assign wr_ack = reg_wr && reg_addr == cpms_pkg::ADDR_ISO_ACK && reg_wdata[cpms_pkg::ACK_BIT];

  always_comb begin
    deep_stop = stop_act_reg inside {cpms_pkg::STOP_DEEP3, cpms_pkg::STOP_DEEP2,
                                     cpms_pkg::STOP_DEEP1, cpms_pkg::STOP_DEEP0,
                                     cpms_pkg::STOP_BACKUP};
    low_leak_stop = stop_act_reg inside {cpms_pkg::STOP_LL_FULL, cpms_pkg::STOP_LL_PARTIAL};
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    run_mode_next = run_mode_reg;
    stop_ctrl_next = stop_ctrl_reg;
    stop_sel_next = stop_sel_reg;
    stop_act_next = stop_act_reg;
    iso_hold_next = iso_hold_reg;
    wake_flag_next = wake_flag_reg;
    resume_flag_next = resume_flag_reg;
    nmi_first_next = nmi_first_reg;
    reset_wake_next = 1'b0;
    resume_next = 1'b0;
    case (state_reg)
      ST_BOOT: begin
        // Straps caught on the first edge after reset release
        run_mode_next = low_power_run_boot ? cpms_pkg::RUN_MODE_SELECT_LOW_POWER : cpms_pkg::RUN_MODE_SELECT_NORMAL; // RULE1
        nmi_first_next = !nmi_pin_n; // RULE8
        state_next = ST_RUN;
      end
      ST_RUN: begin
        if (wr_run) begin
          // RULE3 RULE4
          if (reg_wdata[cpms_pkg::RUN_MODE_SELECT_LSB +: 2] == cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED &&
              run_mode_reg == cpms_pkg::RUN_MODE_SELECT_NORMAL) begin
            run_mode_next = cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED;
          end else if (run_mode_reg == cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED) begin
            run_mode_next = cpms_pkg::RUN_MODE_SELECT_NORMAL;
          end else if (reg_wdata[cpms_pkg::RUN_MODE_SELECT_LSB +: 2] != cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED) begin
            run_mode_next = reg_wdata[cpms_pkg::RUN_MODE_SELECT_LSB +: 2];
          end
        end
        if (wr_stop_ctrl) begin
          stop_ctrl_next = reg_wdata[1:0];
        end
        if (wr_stop_req && run_mode_reg != cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED) begin // RULE5
          stop_sel_next = cpms_pkg::cpms_stop_type'(reg_wdata[3:0]);
        end
        if (wr_ack) begin
          iso_hold_next = 1'b0; // RULE7
        end
        if (reg_rd && reg_addr == cpms_pkg::ADDR_RESET_STATUS) begin
          nmi_first_next = 1'b0;
        end
        if (deep_sleep_req && stop_sel_reg != cpms_pkg::STOP_NONE &&
            stop_sel_reg <= cpms_pkg::STOP_BACKUP &&
            run_mode_reg != cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED) begin // RULE5
          stop_act_next = stop_sel_reg;
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_event) begin // RULE20
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Low-leak and deep stops report the wake
        wake_flag_next = low_leak_stop || deep_stop; // RULE19
        resume_flag_next = !deep_stop;
        if (deep_stop) begin
          // Deep stops recover through the reset flow
          iso_hold_next = 1'b1; // RULE7
          reset_wake_next = 1'b1;
          run_mode_next = cpms_pkg::RUN_MODE_SELECT_NORMAL;
        end else begin
          resume_next = 1'b1; // RULE18
        end
        stop_act_next = cpms_pkg::STOP_NONE;
        stop_sel_next = cpms_pkg::STOP_NONE;
        state_next = ST_RUN;
      end
      default: state_next = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_BOOT;
      run_mode_reg <= cpms_pkg::RUN_MODE_SELECT_NORMAL; // RULE4
      stop_ctrl_reg <= 2'h0;
      stop_sel_reg <= cpms_pkg::STOP_NONE;
      stop_act_reg <= cpms_pkg::STOP_NONE;
      iso_hold_reg <= 1'b0;
      wake_flag_reg <= 1'b0;
      resume_flag_reg <= 1'b0;
      nmi_first_reg <= 1'b0;
      reset_wake_reg <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_mode_reg <= run_mode_next;
      stop_ctrl_reg <= stop_ctrl_next;
      stop_sel_reg <= stop_sel_next;
      stop_act_reg <= stop_act_next;
      iso_hold_reg <= iso_hold_next;
      wake_flag_reg <= wake_flag_next;
      resume_flag_reg <= resume_flag_next;
      nmi_first_reg <= nmi_first_next;
      reset_wake_reg <= reset_wake_next;
      resume_reg <= resume_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Domain and regulator decode
  always_comb begin
    dom_next = '0;
    dom_next.undervoltage_detect_on = 1'b1;
    dom_next.periph_clk_on = 1'b1;
    dom_next.nested_irq_ctrl_on = 1'b1;
    dom_next.leakage_wake_unit_on = 1'b1;
    dom_next.lptimer_cmp_touch_dac_on = 1'b1;
    dom_next.clock_calendar_on = 1'b1;
    dom_next.adc_pin_irq_on = 1'b1;
    dom_next.ram_part1_on = 1'b1;
    dom_next.ram_part2_on = 1'b1;
    dom_next.ram_part3_on = 1'b1;
    dom_next.sram_upper_on = 1'b1;
    dom_next.sram_lower_on = 1'b1;
    dom_next.sys_regfile_on = 1'b1;
    dom_next.backup_regfile_on = 1'b1;
    dom_next.logic_state_kept = 1'b1;
    dom_next.low_power_osc_on = 1'b1;
    dom_next.por_on = 1'b1;
    dom_next.core_power_on = 1'b1;
    dom_next.io_hold = iso_hold_reg; // RULE7
    dom_next.osc_hold = iso_hold_reg; // RULE7
    case (run_mode_reg)
      cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED: regm_next = cpms_pkg::REG_HIGH_SPEED; // RULE3
      cpms_pkg::RUN_MODE_SELECT_LOW_POWER: regm_next = cpms_pkg::REG_LOW_POWER;
      default: regm_next = cpms_pkg::REG_FULL; // RULE2
    endcase
    if (state_reg == ST_STOP) begin
      dom_next.undervoltage_detect_on = 1'b0;
      dom_next.periph_clk_on = 1'b0;
      dom_next.nested_irq_ctrl_on = 1'b0;
      dom_next.io_hold = 1'b1;
      dom_next.osc_hold = 1'b1;
      regm_next = cpms_pkg::REG_RETENTION;
      case (stop_act_reg)
        cpms_pkg::STOP_VLP: begin
          dom_next.async_wake_ctrl_on = 1'b1; // RULE9
          regm_next = cpms_pkg::REG_LOW_POWER;
        end
        cpms_pkg::STOP_LL_FULL: begin
          dom_next.adc_pin_irq_on = 1'b0; // RULE10
        end
        cpms_pkg::STOP_LL_PARTIAL: begin
          dom_next.adc_pin_irq_on = 1'b0;
          dom_next.low_voltage_logic = 1'b1; // RULE12
          dom_next.ram_part3_on = 1'b0;
          dom_next.ram_part2_on = stop_ctrl_reg[cpms_pkg::RAM2_BIT];
          dom_next.sram_lower_on = 1'b0;
        end
        cpms_pkg::STOP_DEEP3: begin
          dom_next.adc_pin_irq_on = 1'b0; // RULE13
          dom_next.logic_state_kept = 1'b0;
        end
        cpms_pkg::STOP_DEEP2: begin
          dom_next.adc_pin_irq_on = 1'b0; // RULE14
          dom_next.sram_lower_on = 1'b0;
          dom_next.ram_part3_on = 1'b0;
          dom_next.ram_part2_on = stop_ctrl_reg[cpms_pkg::RAM2_BIT];
          dom_next.logic_state_kept = 1'b0;
        end
        cpms_pkg::STOP_DEEP1, cpms_pkg::STOP_DEEP0: begin
          dom_next.adc_pin_irq_on = 1'b0; // RULE15
          dom_next.sram_lower_on = 1'b0;
          dom_next.sram_upper_on = 1'b0;
          dom_next.ram_part1_on = 1'b0;
          dom_next.ram_part2_on = 1'b0;
          dom_next.ram_part3_on = 1'b0;
          dom_next.logic_state_kept = 1'b0;
          if (stop_act_reg == cpms_pkg::STOP_DEEP0) begin
            dom_next.lptimer_cmp_touch_dac_on = 1'b0; // RULE16
            dom_next.low_power_osc_on = 1'b0;
            dom_next.por_on = stop_ctrl_reg[cpms_pkg::PORKEEP_BIT];
          end
        end
        cpms_pkg::STOP_BACKUP: begin
          dom_next = '0; // RULE17
          dom_next.clock_calendar_on = 1'b1;
          dom_next.backup_regfile_on = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dom_reg <= '0;
      regm_reg <= cpms_pkg::REG_FULL;
    end else begin
      dom_reg <= dom_next;
      regm_reg <= regm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        cpms_pkg::ADDR_RUN_CTRL: rdata_next[1:0] = run_mode_reg;
        cpms_pkg::ADDR_STOP_CTRL: rdata_next[1:0] = stop_ctrl_reg;
        cpms_pkg::ADDR_STOP_REQ: rdata_next[3:0] = stop_sel_reg;
        cpms_pkg::ADDR_ISO_ACK: rdata_next[0] = iso_hold_reg;
        cpms_pkg::ADDR_STATUS: rdata_next[5:0] = {nmi_first_reg, iso_hold_reg, regm_reg, run_mode_reg};
        cpms_pkg::ADDR_RESET_STATUS: rdata_next[1:0] = {resume_flag_reg, wake_flag_reg};
        cpms_pkg::ADDR_DOMAINS: rdata_next[cpms_pkg::DOMAIN_W-1:0] = dom_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign regulator_mode = regm_reg;
  assign high_speed_run = run_mode_reg == cpms_pkg::RUN_MODE_SELECT_HIGH_SPEED;
  assign low_power_run = run_mode_reg == cpms_pkg::RUN_MODE_SELECT_LOW_POWER;
  assign flash_prog_block = high_speed_run; // RULE6
  assign nmi_first = nmi_first_reg; // RULE8
  assign wake_via_reset = reset_wake_reg;
  assign resume_pulse = resume_reg;
  assign domains = dom_reg;

endmodule
`default_nettype wire

// *** bench/cpms_monitor.sv ***
/*
  Port checker for the power-mode sequencer.
  Assumes a bind from the bench top onto cpms_sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module cpms_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Straps and register port
  input wire logic low_power_run_boot,
  input wire logic nmi_pin_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Stop entry and wake
  input wire logic deep_sleep_req,
  input wire logic wake_event,
  // Status
  input wire logic [1:0] regulator_mode,
  input wire logic high_speed_run,
  input wire logic low_power_run,
  input wire logic flash_prog_block,
  input wire logic nmi_first,
  input wire logic wake_via_reset,
  input wire logic resume_pulse,
  input wire cpms_pkg::cpms_domains_type domains
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_flash_blocked: assert property (flash_prog_block == high_speed_run)
    else $error("flash block differs from high-speed run");
  chk_hs_regulator: assert property ($rose(high_speed_run) |=> regulator_mode == cpms_pkg::REG_HIGH_SPEED)
    else $error("regulator not switched to high speed");
  chk_hs_leave: assert property (high_speed_run && reg_wr && reg_addr == cpms_pkg::ADDR_RUN_CTRL |=> !high_speed_run)
    else $error("run-mode write did not leave high speed");
  chk_hs_no_stop: assert property (high_speed_run && deep_sleep_req |-> ##2 domains.periph_clk_on)
    else $error("stop honoured in high speed");
  chk_boot_mode: assert property ($fell(rst) |-> ##2 low_power_run == $past(low_power_run_boot, 2))
    else $error("run mode after reset wrong");
  chk_boot_regulator: assert property ($fell(rst) && !low_power_run_boot |-> (regulator_mode == 2'h0) [*3])
    else $error("regulator not full after reset");
  chk_nmi_capture: assert property ($fell(rst) |-> ##2 nmi_first == !$past(nmi_pin_n, 2))
    else $error("interrupt pin not captured at release");
  chk_resume_cause: assert property (resume_pulse |-> $past(wake_event, 2) && !wake_via_reset)
    else $error("resume without wake two cycles earlier");
  chk_iso_hold: assert property (wake_via_reset |=> domains.io_hold && domains.osc_hold)
    else $error("pins or oscillator not held after deep wake");
endmodule
`default_nettype wire

// *** bench/cpms_wake_unit.sv ***
/*
  Wake unit model: one wake pulse a chosen number of cycles after arm.
  Assumes arm is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module cpms_wake_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Trigger and delay
  input wire logic arm,
  input wire logic [3:0] wait_cycles,
  // Wake towards the sequencer
  output logic wake_event
);
  logic [4:0] count_reg;

  // Wake source stays unmasked, so every armed wake is delivered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 5'h0;
      wake_event <= 1'b0;
    end else begin
      wake_event <= count_reg == 5'h1;
      if (arm) begin
        count_reg <= {1'b0, wait_cycles} + 5'h1;
      end else if (count_reg != 5'h0) begin
        count_reg <= count_reg - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Bench top: clock, reset, register tasks and one task per scenario.
  Assumes the package, the wake unit model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) begin \
      err_count++; \
      $display("unexpected %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic low_power_run_boot = 1'b0;
  logic nmi_pin_n = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic deep_sleep_req = 1'b0;
  logic arm = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic [31:0] reg_rdata;
  logic [1:0] regulator_mode;
  logic high_speed_run, low_power_run, flash_prog_block, nmi_first, wake_via_reset, resume_pulse, wake_event;
  cpms_pkg::cpms_domains_type domains;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  // Domain bits checked per stop kind, values with both retention controls set
  localparam logic [21:0] MSK [1:8] = '{22'h3c4600, 22'h138600, 22'h003860, 22'h020610,
    22'h003240, 22'h0007d0, 22'h008006, 22'h008781};
  localparam logic [21:0] VAL [1:8] = '{22'h044600, 22'h038600, 22'h003060, 22'h020610,
    22'h003000, 22'h000190, 22'h008002, 22'h008080};

  always #20 clk = ~clk;

  cpms_sequencer i_cpms_sequencer (.clk(clk), .rst(rst), .low_power_run_boot(low_power_run_boot),
    .nmi_pin_n(nmi_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .deep_sleep_req(deep_sleep_req), .wake_event(wake_event),
    .regulator_mode(regulator_mode), .high_speed_run(high_speed_run), .low_power_run(low_power_run),
    .flash_prog_block(flash_prog_block), .nmi_first(nmi_first), .wake_via_reset(wake_via_reset),
    .resume_pulse(resume_pulse), .domains(domains));
  cpms_wake_unit i_cpms_wake_unit (.clk(clk), .rst(rst), .arm(arm), .wait_cycles(wait_cycles),
    .wake_event(wake_event));

  ////////////////////////////////////////////////////////////////////////////
  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic sleep_pulse;
    @(posedge clk);
    deep_sleep_req <= 1'b1;
    @(posedge clk);
    deep_sleep_req <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic boot, input logic nmi_n);
    @(posedge clk);
    rst <= 1'b1;
    low_power_run_boot <= boot;
    nmi_pin_n <= nmi_n;
    clocks(16);
    @(posedge clk);
    rst <= 1'b0;
    clocks(4);
    `CHK("low power run", boot, low_power_run)
    `CHK("regulator", boot ? cpms_pkg::REG_LOW_POWER : cpms_pkg::REG_FULL, regulator_mode)
    `CHK("nmi first", ~nmi_n, nmi_first)
    `CHK("high speed", 1'b0, high_speed_run)
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(cpms_pkg::ADDR_STATUS, d);
    `CHK("status", {cpms_pkg::REG_LOW_POWER, cpms_pkg::RUN_MODE_SELECT_LOW_POWER}, d[3:0])
    rd(cpms_pkg::ADDR_RESET_STATUS, d);
    clocks(1);
    `CHK("nmi cleared", 1'b0, nmi_first)
    rd(4'hf, d);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_run_modes;
    logic [31:0] d;
    // Stop kind chosen in normal run, so only the high-speed guard can refuse entry
    wr(cpms_pkg::ADDR_STOP_REQ, 32'h1);
    wr(cpms_pkg::ADDR_RUN_CTRL, 32'h3);
    clocks(1);
    `CHK("high speed", 1'b1, high_speed_run)
    `CHK("flash block", 1'b1, flash_prog_block)
    `CHK("regulator hs", cpms_pkg::REG_HIGH_SPEED, regulator_mode)
    wr(cpms_pkg::ADDR_STOP_REQ, 32'h2);
    rd(cpms_pkg::ADDR_STOP_REQ, d);
    `CHK("stop select kept", 32'h1, d)
    sleep_pulse();
    clocks(3);
    `CHK("stop refused", 1'b1, domains.periph_clk_on & high_speed_run)
    wr(cpms_pkg::ADDR_RUN_CTRL, 32'h3);
    clocks(2);
    `CHK("left high speed", 1'b0, high_speed_run | flash_prog_block)
    `CHK("regulator full", cpms_pkg::REG_FULL, regulator_mode)
    wr(cpms_pkg::ADDR_RUN_CTRL, 32'h3);
    do_reset(1'b0, 1'b1);
  endtask
  task automatic t_stops;
    logic [31:0] d;
    logic [21:0] ev;
    int t;
    for (int c = 1; c >= 0; c--) begin
      wr(cpms_pkg::ADDR_STOP_CTRL, (c != 0) ? 32'h3 : 32'h0);
      for (int k = 1; k <= 8; k++) begin
        wr(cpms_pkg::ADDR_STOP_REQ, 32'(k));
        sleep_pulse();
        clocks(6);
        ev = (c != 0) ? VAL[k] : VAL[k] & ~22'h001002;
        `CHK("stop domains", ev, domains & MSK[k])
        `CHK("stop regulator", (k == 1) ? cpms_pkg::REG_LOW_POWER : cpms_pkg::REG_RETENTION, regulator_mode)
        @(posedge clk);
        arm <= 1'b1;
        wait_cycles <= 4'(k);
        @(posedge clk);
        arm <= 1'b0;
        t = 0;
        while (!(resume_pulse || wake_via_reset) && t < 40) begin
          clocks(1);
          t++;
        end
        `CHK("resume", k < 4, resume_pulse)
        `CHK("reset flow", k >= 4, wake_via_reset)
        rd(cpms_pkg::ADDR_RESET_STATUS, d);
        // Very-low-power stop is not a low-leak stop and leaves the wake flag clear
        `CHK("wake flags", {k < 4, k >= 2}, d[1:0])
        `CHK("io hold", k >= 4, domains.io_hold)
        wr(cpms_pkg::ADDR_ISO_ACK, 32'h1);
        clocks(2);
        `CHK("hold released", 1'b0, domains.io_hold | domains.osc_hold)
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    do_reset(1'b1, 1'b0);
    t_regs();
    do_reset(1'b0, 1'b1);
    t_run_modes();
    t_stops();
    print_verdict();
  end
endmodule

bind cpms_sequencer cpms_monitor i_cpms_monitor (.clk(clk), .rst(rst), .low_power_run_boot(low_power_run_boot),
  .nmi_pin_n(nmi_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .deep_sleep_req(deep_sleep_req), .wake_event(wake_event),
  .regulator_mode(regulator_mode), .high_speed_run(high_speed_run), .low_power_run(low_power_run),
  .flash_prog_block(flash_prog_block), .nmi_first(nmi_first), .wake_via_reset(wake_via_reset),
  .resume_pulse(resume_pulse), .domains(domains));
`default_nettype wire
